// File: bench/lmq_host.sv
`timescale 1ns/10ps
module lmq_host (
   input  wire logic        clk,
   input  wire logic        reg_ack,
   input  wire logic [31:0] reg_rdata,
   output logic             reg_req,
   output logic             reg_wr,
   output logic      [11:0] reg_addr,
   output logic      [31:0] reg_wdata
);
   initial begin
      reg_req = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 32'h0000_0000;
   end
   // One word access; lines show inverted values once the request is dropped
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
      @(negedge clk);
      reg_req = 1'b1;
      reg_wr = w;
      reg_addr = {a[11:2], 2'b00};
      reg_wdata = d;
      @(negedge clk);
      q = reg_rdata;
      ok = reg_ack;
      reg_req = 1'b0;
      reg_wr = ~w;
      reg_addr = ~reg_addr;
      reg_wdata = ~d;
   endtask
endmodule

// File: bench/lmq_regs_tb.sv
`timescale 1ns/10ps
module lmq_regs_tb;
   import lmq_pkg::*;
   logic        clk, sys_rst, reg_req, reg_wr, evt_used_in, evt_cfg_in;
   logic        reg_ack, irq_out, doorbell_pulse, dev_reset_pulse;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, doorbell_index, accepted_cap0, accepted_cap1;
   logic [63:0] sel_base_addr;
   int          fail_count, total_checks, cycles;

   lmq_regs i_lmq_regs (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .evt_used_in(evt_used_in), .evt_cfg_in(evt_cfg_in),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .irq_out(irq_out), .doorbell_pulse(doorbell_pulse),
      .doorbell_index(doorbell_index), .dev_reset_pulse(dev_reset_pulse), .sel_base_addr(sel_base_addr),
      .accepted_cap0(accepted_cap0), .accepted_cap1(accepted_cap1));
   lmq_host i_lmq_host (.clk(clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_req(reg_req),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count = fail_count + 1;
         results();
      end
   end

   task automatic ck(input string n, input logic [63:0] e, input logic [63:0] s);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        ok;
      i_lmq_host.xfer(1'b1, a, d, q, ok);
      ck("write ack", 64'h1, {63'h0, ok});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      logic        ok;
      i_lmq_host.xfer(1'b0, a, 32'h0, q, ok);
      ck("read ack", 64'h1, {63'h0, ok});
      ck(n, {32'h0, e}, {32'h0, q});
   endtask

   task automatic t_ident();
      rd(LMQ_OFS_REV, LMQ_REV_VALUE, "revision");
      wr(LMQ_OFS_REV, 32'hffff_ffff);
      rd(LMQ_OFS_REV, LMQ_REV_VALUE, "revision kept");
      rd(LMQ_OFS_PAGE, 32'h0, "write only reads zero");
      rd(12'h0f0, 32'h0, "unmapped");
      wr(LMQ_OFS_DOORBELL, 32'h0000_0002);
      ck("doorbell pulse", 64'h1, {63'h0, doorbell_pulse});
      ck("doorbell index", 64'h2, {32'h0, doorbell_index});
   endtask
   task automatic t_rings();
      wr(LMQ_OFS_PAGE, 32'h2000);
      for (int q = 0; q < 5; q++) begin
         wr(LMQ_OFS_RSEL, q);
         rd(LMQ_OFS_RPFN, 32'h0, "idle frame");
         rd(LMQ_OFS_RLIMIT, (q < 4) ? LMQ_RING_LIMIT : 32'h0, "size limit");
         wr(LMQ_OFS_RSIZE, 32'h10 << q);
         wr(LMQ_OFS_RALIGN, 32'h1000 << q);
         wr(LMQ_OFS_RPFN, q + 1);
         rd(LMQ_OFS_RPFN, (q < 4) ? q + 1 : 0, "frame stored");
      end
      for (int q = 4; q >= 0; q--) begin
         wr(LMQ_OFS_RSEL, q);
         rd(LMQ_OFS_RPFN, (q < 4) ? q + 1 : 0, "page frame");
      end
   endtask
   task automatic t_base();
      wr(LMQ_OFS_PAGE, 32'h2000);
      wr(LMQ_OFS_RSEL, 32'h2);
      @(negedge clk);
      ck("base address", 64'h6000, sel_base_addr);
   endtask
   task automatic t_caps();
      wr(LMQ_OFS_OFF_SEL, 32'h0);
      rd(LMQ_OFS_OFF_CAP, LMQ_OFF_CAP0, "offered word 0");
      wr(LMQ_OFS_OFF_SEL, 32'h1);
      rd(LMQ_OFS_OFF_CAP, LMQ_OFF_CAP1, "offered word 1");
      wr(LMQ_OFS_ACC_SEL, 32'h1);
      wr(LMQ_OFS_ACC_CAP, 32'h5);
      wr(LMQ_OFS_ACC_SEL, 32'h0);
      wr(LMQ_OFS_ACC_CAP, 32'h3);
      @(negedge clk);
      ck("accepted word 1", 64'h5, {32'h0, accepted_cap1});
      ck("accepted word 0", 64'h3, {32'h0, accepted_cap0});
   endtask
   task automatic t_events();
      evt_cfg_in = 1'b1;
      @(negedge clk);
      evt_cfg_in = 1'b0;
      ck("irq raised", 64'h1, {63'h0, irq_out});
      evt_used_in = 1'b1;
      @(negedge clk);
      evt_used_in = 1'b0;
      rd(LMQ_OFS_PENDING, 32'h3, "both pending");
      wr(LMQ_OFS_EVCLR, 32'h2);
      rd(LMQ_OFS_PENDING, 32'h1, "one pending");
      ck("irq held", 64'h1, {63'h0, irq_out});
      wr(LMQ_OFS_EVCLR, 32'h1);
      rd(LMQ_OFS_PENDING, 32'h0, "none pending");
      ck("irq dropped", 64'h0, {63'h0, irq_out});
      evt_used_in = 1'b1;
      wr(LMQ_OFS_EVCLR, 32'h1);
      evt_used_in = 1'b0;
      rd(LMQ_OFS_PENDING, 32'h1, "event beats clear");
   endtask
   task automatic t_progress();
      wr(LMQ_OFS_PROGRESS, 32'h7);
      rd(LMQ_OFS_PROGRESS, 32'h7, "progress");
      wr(LMQ_OFS_CFG + 12'h004, 32'h0000_00a5);
      wr(LMQ_OFS_PROGRESS, 32'h0);
      ck("reset pulse", 64'h1, {63'h0, dev_reset_pulse});
      rd(LMQ_OFS_PROGRESS, 32'h0, "progress cleared");
      rd(LMQ_OFS_PENDING, 32'h0, "pending cleared");
      ck("irq cleared", 64'h0, {63'h0, irq_out});
      rd(LMQ_OFS_CFG + 12'h004, 32'h0000_00a5, "config kept");
      for (int q = 0; q < 4; q++) begin
         wr(LMQ_OFS_RSEL, q);
         rd(LMQ_OFS_RPFN, 32'h0, "frame cleared");
      end
   endtask

   initial begin
      fail_count = 0;
      total_checks = 0;
      cycles = 0;
      evt_used_in = 1'b0;
      evt_cfg_in = 1'b0;
      sys_rst = 1'b1;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      t_ident();
      t_rings();
      t_base();
      t_caps();
      t_events();
      t_progress();
      results();
   end
endmodule

// File: shared/lmq_pkg.sv
package lmq_pkg;
   localparam int          LMQ_NUM_Q          = 4;
   localparam int          LMQ_QW             = 2;
   localparam int          LMQ_CFG_WORDS      = 4;
   localparam int          LMQ_NUM_EVT        = 2;
   // Register byte offsets
   localparam logic [11:0] LMQ_OFS_SIG        = 12'h000;
   localparam logic [11:0] LMQ_OFS_REV        = 12'h004;
   localparam logic [11:0] LMQ_OFS_FUNC       = 12'h008;
   localparam logic [11:0] LMQ_OFS_MAKER      = 12'h00c;
   localparam logic [11:0] LMQ_OFS_OFF_CAP    = 12'h010;
   localparam logic [11:0] LMQ_OFS_OFF_SEL    = 12'h014;
   localparam logic [11:0] LMQ_OFS_ACC_CAP    = 12'h020;
   localparam logic [11:0] LMQ_OFS_ACC_SEL    = 12'h024;
   localparam logic [11:0] LMQ_OFS_PAGE       = 12'h028;
   localparam logic [11:0] LMQ_OFS_RSEL       = 12'h030;
   localparam logic [11:0] LMQ_OFS_RLIMIT     = 12'h034;
   localparam logic [11:0] LMQ_OFS_RSIZE      = 12'h038;
   localparam logic [11:0] LMQ_OFS_RALIGN     = 12'h03c;
   localparam logic [11:0] LMQ_OFS_RPFN       = 12'h040;
   localparam logic [11:0] LMQ_OFS_DOORBELL   = 12'h050;
   localparam logic [11:0] LMQ_OFS_PENDING    = 12'h060;
   localparam logic [11:0] LMQ_OFS_EVCLR      = 12'h064;
   localparam logic [11:0] LMQ_OFS_PROGRESS   = 12'h070;
   localparam logic [11:0] LMQ_OFS_CFG        = 12'h100;
   // Fixed read values
   localparam logic [31:0] LMQ_REV_VALUE      = 32'h0000_0001;
   localparam logic [31:0] LMQ_SIG_VALUE      = 32'h5a5a_1234; // Arbitrary value
   localparam logic [31:0] LMQ_FUNC_VALUE     = 32'h0000_0003; // Arbitrary value
   localparam logic [31:0] LMQ_MAKER_VALUE    = 32'h0000_abcd; // Arbitrary value
   localparam logic [31:0] LMQ_OFF_CAP0       = 32'h0000_0011;
   localparam logic [31:0] LMQ_OFF_CAP1       = 32'h0000_0000;
   localparam logic [31:0] LMQ_RING_LIMIT     = 32'h0000_0100;
   // Pending event bit positions
   localparam int          LMQ_EVT_USED       = 0;
   localparam int          LMQ_EVT_CFG        = 1;
   // Reset values
   localparam logic [31:0] LMQ_ZERO           = 32'h0000_0000;
   localparam logic [31:0] LMQ_PAGE_RESET     = 32'h0000_1000;
   localparam logic [31:0] LMQ_ALIGN_RESET    = 32'h0000_1000;
endpackage

// File: verilog/lmq_regs.sv
`timescale 1ns/10ps
module lmq_regs
   import lmq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        reg_req,
   input  wire logic        reg_wr,
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        evt_used_in,
   input  wire logic        evt_cfg_in,
   output logic      [31:0] reg_rdata,
   output logic             reg_ack,
   output logic             irq_out,
   output logic             doorbell_pulse,
   output logic      [31:0] doorbell_index,
   output logic             dev_reset_pulse,
   output logic      [63:0] sel_base_addr,
   output logic      [31:0] accepted_cap0,
   output logic      [31:0] accepted_cap1
);

   typedef logic [31:0] lmq_word_t;

   lmq_word_t                    off_sel_reg;
   lmq_word_t                    acc_sel_reg;
   lmq_word_t                    acc_cap_reg [LMQ_QW];
   lmq_word_t                    page_reg;
   lmq_word_t                    rsel_reg;
   lmq_word_t                    rsize_reg   [LMQ_NUM_Q];
   lmq_word_t                    ralign_reg  [LMQ_NUM_Q];
   lmq_word_t                    rpfn_reg    [LMQ_NUM_Q];
   lmq_word_t                    progress_reg;
   lmq_word_t                    cfg_reg     [LMQ_CFG_WORDS];
   logic      [LMQ_NUM_EVT-1:0]  pending_reg;
   logic      [LMQ_NUM_EVT-1:0]  pending_next;
   logic      [LMQ_NUM_EVT-1:0]  evt_set;
   logic                         wr_en;
   logic                         rd_en;
   logic                         soft_rst;
   logic                         q_ok;
   logic      [1:0]              q_idx;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [1:0] cfg_slot(input logic [11:0] a);
      cfg_slot = a[3:2];
   endfunction

   function automatic logic cfg_hit(input logic [11:0] a);
      cfg_hit = (a[11:4] == LMQ_OFS_CFG[11:4]);
   endfunction

   assign wr_en    = reg_req && reg_wr;
   assign rd_en    = reg_req && !reg_wr;
   // Selects outside the implemented queues address nothing
   assign q_ok     = (rsel_reg < 32'(LMQ_NUM_Q));
   assign q_idx    = rsel_reg[1:0];
   assign soft_rst = wr_en && hit(reg_addr, LMQ_OFS_PROGRESS) && (reg_wdata == LMQ_ZERO);
   assign evt_set  = {evt_cfg_in, evt_used_in};

   // Global configuration writes
   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         off_sel_reg <= LMQ_ZERO;
         acc_sel_reg <= LMQ_ZERO;
         page_reg    <= LMQ_PAGE_RESET;
         rsel_reg    <= LMQ_ZERO;
      end else if (wr_en) begin
         if (hit(reg_addr, LMQ_OFS_OFF_SEL)) begin
            off_sel_reg <= reg_wdata;
         end
         if (hit(reg_addr, LMQ_OFS_ACC_SEL)) begin
            acc_sel_reg <= reg_wdata;
         end
         if (hit(reg_addr, LMQ_OFS_PAGE)) begin
            page_reg <= reg_wdata;
         end
         if (hit(reg_addr, LMQ_OFS_RSEL)) begin
            rsel_reg <= reg_wdata;
         end
      end
   end

   // Accepted capability words, indexed by their select
   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         for (int i = 0; i < LMQ_QW; i++) begin
            acc_cap_reg[i] <= LMQ_ZERO;
         end
      end else if (wr_en && hit(reg_addr, LMQ_OFS_ACC_CAP) && acc_sel_reg < 32'(LMQ_QW)) begin
         acc_cap_reg[acc_sel_reg[0]] <= reg_wdata;
      end
   end

   // Per-queue storage; only the selected entry changes
   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         for (int i = 0; i < LMQ_NUM_Q; i++) begin
            rsize_reg[i]  <= LMQ_ZERO;
            ralign_reg[i] <= LMQ_ALIGN_RESET;
            rpfn_reg[i]   <= LMQ_ZERO;
         end
      end else if (wr_en && q_ok) begin
         if (hit(reg_addr, LMQ_OFS_RSIZE)) begin
            rsize_reg[q_idx] <= reg_wdata;
         end
         if (hit(reg_addr, LMQ_OFS_RALIGN)) begin
            ralign_reg[q_idx] <= reg_wdata;
         end
         if (hit(reg_addr, LMQ_OFS_RPFN)) begin
            rpfn_reg[q_idx] <= reg_wdata;
         end
      end
   end

   // Driver progress flags; a zero write is the soft reset instead
   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         progress_reg <= LMQ_ZERO;
      end else if (wr_en && hit(reg_addr, LMQ_OFS_PROGRESS)) begin
         progress_reg <= reg_wdata;
      end
   end

   // Function-specific space survives a soft reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < LMQ_CFG_WORDS; i++) begin
            cfg_reg[i] <= LMQ_ZERO;
         end
      end else if (wr_en && cfg_hit(reg_addr)) begin
         cfg_reg[cfg_slot(reg_addr)] <= reg_wdata;
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle
   always_comb begin
      pending_next = pending_reg;
      if (wr_en && hit(reg_addr, LMQ_OFS_EVCLR)) begin
         pending_next = pending_next & ~reg_wdata[LMQ_NUM_EVT-1:0];
      end
      pending_next = pending_next | evt_set;
   end

   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         pending_reg <= '0;
         irq_out     <= 1'b0;
      end else begin
         pending_reg <= pending_next;
         irq_out     <= |pending_next;
      end
   end

   // Read data path
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= LMQ_ZERO;
         reg_ack   <= 1'b0;
      end else begin
         reg_ack <= reg_req;
         if (rd_en) begin
            if (cfg_hit(reg_addr)) begin
               reg_rdata <= cfg_reg[cfg_slot(reg_addr)];
            end else begin
               case (reg_addr)
                  LMQ_OFS_SIG:      reg_rdata <= LMQ_SIG_VALUE;
                  LMQ_OFS_REV:      reg_rdata <= LMQ_REV_VALUE;
                  LMQ_OFS_FUNC:     reg_rdata <= LMQ_FUNC_VALUE;
                  LMQ_OFS_MAKER:    reg_rdata <= LMQ_MAKER_VALUE;
                  LMQ_OFS_OFF_CAP:  reg_rdata <= (off_sel_reg == LMQ_ZERO) ? LMQ_OFF_CAP0 :
                                                 (off_sel_reg == 32'h0000_0001) ? LMQ_OFF_CAP1 : LMQ_ZERO;
                  LMQ_OFS_RLIMIT:   reg_rdata <= q_ok ? LMQ_RING_LIMIT : LMQ_ZERO;
                  LMQ_OFS_RPFN:     reg_rdata <= q_ok ? rpfn_reg[q_idx] : LMQ_ZERO;
                  LMQ_OFS_PENDING:  reg_rdata <= {{(32-LMQ_NUM_EVT){1'b0}}, pending_reg};
                  LMQ_OFS_PROGRESS: reg_rdata <= progress_reg;
                  default:          reg_rdata <= LMQ_ZERO;
               endcase
            end
         end
      end
   end

   // Doorbell and soft reset strobes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         doorbell_pulse  <= 1'b0;
         doorbell_index  <= LMQ_ZERO;
         dev_reset_pulse <= 1'b0;
      end else begin
         doorbell_pulse  <= wr_en && hit(reg_addr, LMQ_OFS_DOORBELL);
         dev_reset_pulse <= soft_rst;
         if (wr_en && hit(reg_addr, LMQ_OFS_DOORBELL)) begin
            doorbell_index <= reg_wdata;
         end
      end
   end

   // Guest address of the selected queue's first page
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_base_addr <= 64'h0;
      end else begin
         sel_base_addr <= q_ok ? (64'(rpfn_reg[q_idx]) * 64'(page_reg)) : 64'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         accepted_cap0 <= LMQ_ZERO;
         accepted_cap1 <= LMQ_ZERO;
      end else begin
         accepted_cap0 <= acc_cap_reg[0];
         accepted_cap1 <= acc_cap_reg[1];
      end
   end

   // Checks
   sequence s_pfn_write;
      wr_en && q_ok && hit(reg_addr, LMQ_OFS_RPFN) && !soft_rst;
   endsequence

   sequence s_pfn_read;
      rd_en && hit(reg_addr, LMQ_OFS_RPFN);
   endsequence

   chk_rev_read_one: assert property (@(posedge clk) disable iff (sys_rst)
      rd_en && hit(reg_addr, LMQ_OFS_REV) |=> reg_ack && reg_rdata == LMQ_REV_VALUE)
      else $error("revision read not one");

   chk_limit_no_queue: assert property (@(posedge clk) disable iff (sys_rst)
      rd_en && hit(reg_addr, LMQ_OFS_RLIMIT) |=> reg_rdata == ($past(q_ok) ? LMQ_RING_LIMIT : LMQ_ZERO))
      else $error("size limit read wrong");

   chk_pfn_round_trip: assert property (@(posedge clk) disable iff (sys_rst)
      (s_pfn_write ##1 (s_pfn_read and ($stable(rsel_reg) && !wr_en))) |=>
         reg_rdata == $past(reg_wdata, 2))
      else $error("page frame not read back");

   chk_soft_reset_pfn: assert property (@(posedge clk) disable iff (sys_rst)
      soft_rst |=> rpfn_reg[0] == LMQ_ZERO && rpfn_reg[LMQ_NUM_Q-1] == LMQ_ZERO && dev_reset_pulse)
      else $error("soft reset left page frame");

   chk_progress_store: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit(reg_addr, LMQ_OFS_PROGRESS) && reg_wdata != LMQ_ZERO |=> progress_reg == $past(reg_wdata))
      else $error("progress flags not stored");

   chk_event_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      evt_used_in && !soft_rst |=> pending_reg[LMQ_EVT_USED] ##1
         (pending_reg[LMQ_EVT_USED] || $past(wr_en && hit(reg_addr, LMQ_OFS_EVCLR)
                                               && reg_wdata[LMQ_EVT_USED]) || $past(soft_rst)))
      else $error("event bit lost");

   chk_irq_follows: assert property (@(posedge clk) disable iff (sys_rst)
      irq_out == (|pending_reg))
      else $error("interrupt line disagrees with pending");

   chk_select_isolate: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && q_ok && q_idx != 2'd0 && !soft_rst |=> $stable(rsize_reg[0]) && $stable(rpfn_reg[0]))
      else $error("unselected queue changed");

   chk_base_product: assert property (@(posedge clk) disable iff (sys_rst)
      q_ok && $stable(rsel_reg) |=> sel_base_addr == 64'($past(rpfn_reg[q_idx])) * 64'($past(page_reg)))
      else $error("base address wrong");

   // Host accesses leave one idle cycle between requests
   chk_pfn_spaced: assert property (@(posedge clk) disable iff (sys_rst)
      (s_pfn_write ##1 !reg_req ##1 (s_pfn_read and $stable(rsel_reg))) |=>
         reg_rdata == $past(reg_wdata, 3))
      else $error("spaced page frame not read back");

   chk_pfn_read_sel: assert property (@(posedge clk) disable iff (sys_rst)
      rd_en && hit(reg_addr, LMQ_OFS_RPFN) |=> reg_rdata == ($past(q_ok) ? $past(rpfn_reg[q_idx]) : LMQ_ZERO))
      else $error("page frame read wrong");

   chk_size_stored: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && q_ok && hit(reg_addr, LMQ_OFS_RSIZE) |=> rsize_reg[q_idx] == $past(reg_wdata))
      else $error("queue size not stored");

   chk_align_stored: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && q_ok && hit(reg_addr, LMQ_OFS_RALIGN) |=> ralign_reg[q_idx] == $past(reg_wdata))
      else $error("ring alignment not stored");

   chk_page_stored: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit(reg_addr, LMQ_OFS_PAGE) |=> page_reg == $past(reg_wdata))
      else $error("page size not stored");

   chk_select_stored: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit(reg_addr, LMQ_OFS_RSEL) |=> rsel_reg == $past(reg_wdata))
      else $error("queue select not stored");

   chk_soft_reset_clear: assert property (@(posedge clk) disable iff (sys_rst)
      soft_rst |=> progress_reg == LMQ_ZERO && pending_reg == '0 && !irq_out)
      else $error("soft reset left flags or events");

   chk_reset_pulse_cause: assert property (@(posedge clk) disable iff (sys_rst)
      dev_reset_pulse |-> $past(soft_rst))
      else $error("reset pulse without zero write");

   chk_event_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      evt_cfg_in && !soft_rst |=> pending_reg[LMQ_EVT_CFG])
      else $error("config event lost");

   chk_event_cleared: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit(reg_addr, LMQ_OFS_EVCLR) && reg_wdata[LMQ_EVT_CFG] && !evt_cfg_in |=> !pending_reg[LMQ_EVT_CFG])
      else $error("config event not cleared");

   chk_progress_read: assert property (@(posedge clk) disable iff (sys_rst)
      rd_en && hit(reg_addr, LMQ_OFS_PROGRESS) |=> reg_rdata == $past(progress_reg))
      else $error("progress flags read wrong");

   chk_offered_word: assert property (@(posedge clk) disable iff (sys_rst)
      rd_en && hit(reg_addr, LMQ_OFS_OFF_CAP) && off_sel_reg == LMQ_ZERO |=> reg_rdata == LMQ_OFF_CAP0)
      else $error("offered word 0 read wrong");

   chk_accepted_word: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit(reg_addr, LMQ_OFS_ACC_CAP) && acc_sel_reg == LMQ_ZERO |=> acc_cap_reg[0] == $past(reg_wdata))
      else $error("accepted word 0 not stored");

endmodule
